// ===== hdl/rst_nmi_pkg.sv
package rst_nmi_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Control field positions
  localparam int CTRL_BIDIR_BIT = 0;
  localparam int CTRL_PD_CFG_BIT = 1;
  localparam int CTRL_OSC_OFF_BIT = 2;
  localparam int CTRL_SWRST_BIT = 3;

  // Status field positions
  localparam int STAT_RSTIND_BIT = 0;
  localparam int STAT_SEQ_BIT = 1;
  localparam int STAT_PD_BIT = 2;
  localparam int STAT_SYNCRST_BIT = 3;
  localparam int STAT_CAUSE_LSB = 4;

  // Values after reset
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [2:0] CAUSE_RESET = 3'h0;

  // Reset cause one-hot codes
  localparam logic [2:0] CAUSE_HW = 3'h1;
  localparam logic [2:0] CAUSE_SW = 3'h2;
  localparam logic [2:0] CAUSE_WDT = 3'h4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PIN_RESET_MIN_NS = 1000;
  localparam int PIN_RESET_MIN_CYCLES =
    (PIN_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_SEQ_CYCLES_DEF = 1024;
  localparam int CNT_W = 16;

  typedef enum logic [3:0] {
    st_in_reset = 4'h1,
    st_wait_init = 4'h2,
    st_running = 4'h4,
    st_powered_down = 4'h8
  } mode_type;

  typedef struct packed {
    mode_type mode;
    logic [CNT_W-1:0] seq_cnt;
    logic [CNT_W-1:0] filt_cnt;
    logic bidir_en;
    logic powerdown_config_bit;
    logic osc_off;
    logic sync_reset_mode;
    logic [2:0] cause;
    logic nmi_prev;
    logic nmi_trap;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;

endpackage

// ===== hdl/reset_and_nmi_pin_control.sv
`timescale 1ns/1ps
// How it works
// [R1] Low reset pin long enough starts reset
// [R2] Bidirectional mode drives reset pin low
// [R3] Indication low on hardware, software, watchdog reset
// [R4] Indication stays low until end-of-init
// [R5] Falling interrupt pin raises trap request, except during the reset sequence
// [R6] Power-down entered with interrupt pin low, or with the power-down config bit set
// [R7] Interrupt pin high: power-down instruction ignored unless the power-down config bit is set
// [R8] Software sets oscillator off when unused
// [R9] Timing pin picks reset mode, times wake
// [R10] Pin released when reset sequence ends
module reset_and_nmi_pin_control #(
  parameter int RESET_SEQ_CYCLES = rst_nmi_pkg::RESET_SEQ_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_reset_in_n_i,
  output logic ext_reset_in_n_o,
  output logic ext_reset_in_n_oe,
  output logic reset_indication_out_n,
  input wire logic nmi_pin,
  input wire logic powerdown_timing_pin,
  input wire logic watchdog_reset_req,
  input wire logic end_of_init_instruction,
  input wire logic powerdown_instruction,
  output logic internal_reset,
  output logic nmi_trap_req,
  output logic powerdown_active,
  output logic sync_reset_mode,
  output logic lowfreq_osc_off
);

  // Reject sequence lengths that the counter cannot hold
  if (RESET_SEQ_CYCLES < 1 || RESET_SEQ_CYCLES >= (1 << rst_nmi_pkg::CNT_W)) begin : g_seq_check
    $error("RESET_SEQ_CYCLES out of range");
  end

  localparam logic [rst_nmi_pkg::CNT_W-1:0] SEQ_LAST = rst_nmi_pkg::CNT_W'(RESET_SEQ_CYCLES - 1);
  localparam logic [rst_nmi_pkg::CNT_W-1:0] FILT_LAST =
    rst_nmi_pkg::CNT_W'(rst_nmi_pkg::PIN_RESET_MIN_CYCLES - 1);

  rst_nmi_pkg::state_type state_ff;
  rst_nmi_pkg::state_type nxt_state;
  logic in_seq;
  logic hw_reset;
  logic sw_reset;
  logic nmi_fall;
  logic do_write;
  logic do_read;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [3:0] rd_addr;

  assign in_seq = (state_ff.mode == rst_nmi_pkg::st_in_reset);
  assign nmi_fall = state_ff.nmi_prev & ~nmi_pin; // R5
  assign do_write = state_ff.aw_held & state_ff.w_held & ~state_ff.bvalid;
  assign do_read = s_axi_arvalid & ~state_ff.rvalid;
  assign rd_addr = s_axi_araddr[3:0];
  assign sw_reset = do_write && state_ff.aw_addr == rst_nmi_pkg::CTRL_OFFSET
    && state_ff.w_strb[0] && state_ff.w_data[rst_nmi_pkg::CTRL_SWRST_BIT];
  // Own drive of the pin is not mistaken for an outside reset
  assign hw_reset = ~ext_reset_in_n_i & ~ext_reset_in_n_oe
    & (state_ff.filt_cnt == FILT_LAST); // R1

  always_comb begin
    ctrl_word = '0;
    ctrl_word[rst_nmi_pkg::CTRL_BIDIR_BIT] = state_ff.bidir_en;
    ctrl_word[rst_nmi_pkg::CTRL_PD_CFG_BIT] = state_ff.powerdown_config_bit;
    ctrl_word[rst_nmi_pkg::CTRL_OSC_OFF_BIT] = state_ff.osc_off;
    status_word = '0;
    status_word[rst_nmi_pkg::STAT_RSTIND_BIT] = ~reset_indication_out_n;
    status_word[rst_nmi_pkg::STAT_SEQ_BIT] = in_seq;
    status_word[rst_nmi_pkg::STAT_PD_BIT] = powerdown_active;
    status_word[rst_nmi_pkg::STAT_SYNCRST_BIT] = state_ff.sync_reset_mode;
    status_word[rst_nmi_pkg::STAT_CAUSE_LSB +: 3] = state_ff.cause;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.nmi_prev = nmi_pin;
    nxt_state.nmi_trap = nmi_fall & ~in_seq; // R5
    // Minimum-duration filter on the reset pin
    if (~ext_reset_in_n_i & ~ext_reset_in_n_oe) begin
      if (state_ff.filt_cnt != FILT_LAST) begin
        nxt_state.filt_cnt = state_ff.filt_cnt + 1'b1;
      end
    end else begin
      nxt_state.filt_cnt = '0;
    end
    unique case (state_ff.mode)
      rst_nmi_pkg::st_in_reset: begin
        if (state_ff.seq_cnt == SEQ_LAST) begin
          nxt_state.mode = rst_nmi_pkg::st_wait_init; // R10
          nxt_state.sync_reset_mode = powerdown_timing_pin; // R9
        end else begin
          nxt_state.seq_cnt = state_ff.seq_cnt + 1'b1;
        end
      end
      rst_nmi_pkg::st_wait_init: begin
        if (end_of_init_instruction) begin
          nxt_state.mode = rst_nmi_pkg::st_running; // R4
        end
      end
      rst_nmi_pkg::st_running: begin
        if (powerdown_instruction && (state_ff.powerdown_config_bit || ~nmi_pin)) begin
          nxt_state.mode = rst_nmi_pkg::st_powered_down; // R6 R7
        end
      end
      rst_nmi_pkg::st_powered_down: begin
        // Interruptible power-down wakes on interrupt once timing pin is high
        if (state_ff.powerdown_config_bit && nmi_fall && powerdown_timing_pin) begin
          nxt_state.mode = rst_nmi_pkg::st_running; // R9
        end
      end
      default: begin
        nxt_state.mode = rst_nmi_pkg::st_in_reset;
      end
    endcase
    if (hw_reset || sw_reset || watchdog_reset_req) begin
      nxt_state.mode = rst_nmi_pkg::st_in_reset; // R3
      nxt_state.seq_cnt = '0;
      nxt_state.filt_cnt = '0;
      nxt_state.cause = hw_reset ? rst_nmi_pkg::CAUSE_HW :
        (watchdog_reset_req ? rst_nmi_pkg::CAUSE_WDT : rst_nmi_pkg::CAUSE_SW);
    end
    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_state.aw_held = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_state.w_held = 1'b1;
      nxt_state.w_data = s_axi_wdata;
      nxt_state.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = rst_nmi_pkg::RESP_OKAY;
      if (state_ff.aw_addr == rst_nmi_pkg::CTRL_OFFSET) begin
        if (state_ff.w_strb[0]) begin
          nxt_state.bidir_en = state_ff.w_data[rst_nmi_pkg::CTRL_BIDIR_BIT]; // R2
          nxt_state.powerdown_config_bit = state_ff.w_data[rst_nmi_pkg::CTRL_PD_CFG_BIT];
          nxt_state.osc_off = state_ff.w_data[rst_nmi_pkg::CTRL_OSC_OFF_BIT]; // R8
        end
      end else if (state_ff.aw_addr != rst_nmi_pkg::STATUS_OFFSET) begin
        nxt_state.bresp = rst_nmi_pkg::RESP_SLVERR;
      end
    end
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (do_read) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = rst_nmi_pkg::RESP_OKAY;
      if (rd_addr == rst_nmi_pkg::CTRL_OFFSET) begin
        nxt_state.rdata = ctrl_word;
      end else if (rd_addr == rst_nmi_pkg::STATUS_OFFSET) begin
        nxt_state.rdata = status_word;
      end else begin
        nxt_state.rdata = '0;
        nxt_state.rresp = rst_nmi_pkg::RESP_SLVERR;
      end
    end else if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= '0;
      state_ff.mode <= rst_nmi_pkg::st_in_reset;
      state_ff.bidir_en <= rst_nmi_pkg::CTRL_RESET[rst_nmi_pkg::CTRL_BIDIR_BIT];
      state_ff.powerdown_config_bit <= rst_nmi_pkg::CTRL_RESET[rst_nmi_pkg::CTRL_PD_CFG_BIT];
      state_ff.osc_off <= rst_nmi_pkg::CTRL_RESET[rst_nmi_pkg::CTRL_OSC_OFF_BIT];
      state_ff.cause <= rst_nmi_pkg::CAUSE_RESET;
      state_ff.nmi_prev <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign s_axi_awready = ~state_ff.aw_held & ~state_ff.bvalid;
  assign s_axi_wready = ~state_ff.w_held & ~state_ff.bvalid;
  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_arready = ~state_ff.rvalid;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;

  assign ext_reset_in_n_o = 1'b0;
  assign ext_reset_in_n_oe = in_seq & state_ff.bidir_en; // R2 R10
  assign reset_indication_out_n = ~(in_seq | (state_ff.mode == rst_nmi_pkg::st_wait_init)); // R3 R4
  assign internal_reset = in_seq;
  assign nmi_trap_req = state_ff.nmi_trap;
  assign powerdown_active = (state_ff.mode == rst_nmi_pkg::st_powered_down);
  assign sync_reset_mode = state_ff.sync_reset_mode;
  assign lowfreq_osc_off = state_ff.osc_off;

endmodule // reset_and_nmi_pin_control

// ===== verif/reset_and_nmi_pin_control_properties.sv
`timescale 1ns/1ps
module rst_nmi_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_reset_in_n_i,
  input wire logic ext_reset_in_n_o,
  input wire logic ext_reset_in_n_oe,
  input wire logic reset_indication_out_n,
  input wire logic nmi_pin,
  input wire logic watchdog_reset_req,
  input wire logic end_of_init_instruction,
  input wire logic powerdown_instruction,
  input wire logic internal_reset,
  input wire logic nmi_trap_req,
  input wire logic powerdown_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Consecutive low samples of the reset pin while it is not self-driven
  logic [8:0] low_cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || ext_reset_in_n_i || ext_reset_in_n_oe) low_cnt_ff <= 9'h0;
    else if (low_cnt_ff != 9'h1ff) low_cnt_ff <= low_cnt_ff + 9'h1;
  end
  sequence seq_end; internal_reset ##1 !internal_reset; endsequence
  sequence nmi_fall; $past(nmi_pin) && !nmi_pin && !internal_reset; endsequence
  a_pin_reset: assert property (
    !ext_reset_in_n_i && !ext_reset_in_n_oe
    && low_cnt_ff == 9'(rst_nmi_pkg::PIN_RESET_MIN_CYCLES - 1) |-> ##[1:2] internal_reset)
    else $error("pin reset not started");
  a_oe_scope: assert property (ext_reset_in_n_oe |-> internal_reset && !ext_reset_in_n_o)
    else $error("reset pin driven outside sequence");
  a_oe_release: assert property (seq_end |-> !ext_reset_in_n_oe)
    else $error("reset pin still driven");
  a_ind_in_reset: assert property (internal_reset |-> !reset_indication_out_n)
    else $error("indication high in reset");
  a_ind_hold: assert property (
    !reset_indication_out_n && !end_of_init_instruction |=> !reset_indication_out_n)
    else $error("indication released early");
  a_ind_release: assert property (!reset_indication_out_n && !internal_reset
    && end_of_init_instruction && !watchdog_reset_req && ext_reset_in_n_i
    |=> reset_indication_out_n) else $error("indication not released");
  a_trap_raise: assert property (nmi_fall |=> nmi_trap_req)
    else $error("trap missing");
  a_trap_cause: assert property (nmi_trap_req |-> $past(nmi_pin, 2) && !$past(nmi_pin))
    else $error("trap without falling edge");
  a_pd_enter: assert property (reset_indication_out_n && !powerdown_active
    && powerdown_instruction && !nmi_pin && !watchdog_reset_req && ext_reset_in_n_i
    |=> powerdown_active) else $error("power-down not entered");
  a_pd_cause: assert property ($rose(powerdown_active) |-> $past(powerdown_instruction))
    else $error("power-down without instruction");
endmodule // rst_nmi_checker
bind reset_and_nmi_pin_control rst_nmi_checker i_checker (.aclk, .aresetn, .ext_reset_in_n_i,
  .ext_reset_in_n_o, .ext_reset_in_n_oe, .reset_indication_out_n, .nmi_pin, .watchdog_reset_req,
  .end_of_init_instruction, .powerdown_instruction, .internal_reset, .nmi_trap_req,
  .powerdown_active);

// ===== verif/board_reset_nmi_model.sv
`timescale 1ns/1ps
module board_reset_nmi_model (
  input wire logic hold_reset,
  input wire logic nmi_level,
  input wire logic dev_drive,
  input wire logic dev_level,
  output logic pin_level,
  output logic nmi_pin
);
  // Pull-up restores the line when neither party pulls it low
  assign pin_level = dev_drive ? dev_level : !hold_reset;
  assign nmi_pin = nmi_level;
endmodule // board_reset_nmi_model

// ===== verif/tb_reset_and_nmi_pin_control.sv
`timescale 1ns/1ps
module tb_reset_and_nmi_pin_control;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, pin_i, pin_o, pin_oe, ind_n, nmi, tpin, wdt, eoi, pd, irst, trap;
  logic pd_act, sync_m, osc_off, hold, nmi_lvl, seen, early;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0] bresp, rresp, r;
  int miscompares = 0;
  int num_checks = 0;
  reset_and_nmi_pin_control #(.RESET_SEQ_CYCLES(8)) i_dut (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_reset_in_n_i(pin_i),
    .ext_reset_in_n_o(pin_o), .ext_reset_in_n_oe(pin_oe), .reset_indication_out_n(ind_n),
    .nmi_pin(nmi), .powerdown_timing_pin(tpin), .watchdog_reset_req(wdt),
    .end_of_init_instruction(eoi), .powerdown_instruction(pd), .internal_reset(irst),
    .nmi_trap_req(trap), .powerdown_active(pd_act), .sync_reset_mode(sync_m),
    .lowfreq_osc_off(osc_off));
  board_reset_nmi_model i_board (.hold_reset(hold), .nmi_level(nmi_lvl), .dev_drive(pin_oe),
    .dev_level(pin_o), .pin_level(pin_i), .nmi_pin(nmi));
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  task automatic tick(); @(posedge aclk); #1; endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 60) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge aclk);
    {awaddr, wdata} <= {a, v};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      n++;
    end while (bvalid !== 1'h1 && n < 60);
    tmo(n);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      n++;
    end while (rvalid !== 1'h1 && n < 60);
    tmo(n);
    {d, r} = {rdata, rresp};
    rready <= 1'h0;
  endtask
  task automatic wait_seq();
    int n = 0;
    while (irst !== 1'h0 && n < 60) begin
      tick();
      n++;
    end
    tmo(n);
  endtask
  task automatic pulse_eoi(input string t);
    @(posedge aclk) eoi <= 1'h1;
    @(posedge aclk) eoi <= 1'h0;
    tick();
    chk("indication", 1, ind_n);
    $display("test %s finished", t);
  endtask
  task automatic pulse_pd(input logic e);
    @(posedge aclk) pd <= 1'h1;
    @(posedge aclk) pd <= 1'h0;
    repeat (2) tick();
    chk("powerdown", e, pd_act);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, wdt, eoi, pd, hold, aresetn} = '0;
    {awaddr, wdata, araddr} = '0;
    {tpin, nmi_lvl, seen, early} = 4'hc;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    wait_seq();
    chk("indication", 0, ind_n);
    chk("sync_mode", 1, sync_m);
    pulse_eoi("boot");
    @(posedge aclk) nmi_lvl <= 1'h0;
    repeat (5) begin
      tick();
      seen = seen | (trap === 1'h1);
    end
    chk("trap", 1, seen);
    @(posedge aclk) nmi_lvl <= 1'h1;
    pulse_pd(1'h0);
    @(posedge aclk) nmi_lvl <= 1'h0;
    pulse_pd(1'h1);
    @(posedge aclk) {tpin, wdt} <= 2'h1;
    @(posedge aclk) wdt <= 1'h0;
    tick();
    chk("indication", 0, ind_n);
    wait_seq();
    chk("powerdown", 0, pd_act);
    axi_rd(32'h4);
    chk("cause", rst_nmi_pkg::CAUSE_WDT, d[6:4]);
    chk("status", 32'h41, d);
    chk("sync_mode", 0, sync_m);
    pulse_eoi("watchdog");
    @(posedge aclk) nmi_lvl <= 1'h1;
    axi_wr(32'h0, 32'h5);
    chk("bresp", rst_nmi_pkg::RESP_OKAY, r);
    tick();
    chk("osc_off", 1, osc_off);
    axi_wr(32'h0, 32'hd);
    chk("bresp", rst_nmi_pkg::RESP_OKAY, r);
    tick();
    chk("pin_drive", 1, pin_oe);
    axi_rd(32'h4);
    chk("cause", rst_nmi_pkg::CAUSE_SW, d[6:4]);
    wait_seq();
    tick();
    chk("pin_drive", 0, pin_oe);
    pulse_eoi("software");
    {seen, early} = 2'h0;
    @(posedge aclk) hold <= 1'h1;
    for (int i = 0; i < 260; i++) begin
      tick();
      if (irst === 1'h1) begin
        {seen, early} = {1'h1, early | (i < rst_nmi_pkg::PIN_RESET_MIN_CYCLES - 1)};
      end
    end
    chk("pin_reset", 1, seen);
    chk("pin_early", 0, early);
    @(posedge aclk) hold <= 1'h0;
    wait_seq();
    axi_rd(32'h4);
    chk("cause", rst_nmi_pkg::CAUSE_HW, d[6:4]);
    pulse_eoi("pin");
    axi_rd(32'h8);
    chk("rresp", rst_nmi_pkg::RESP_SLVERR, r);
    chk("rdata", 0, d);
    axi_rd(32'h0);
    chk("ctrl", 32'h5, d);
    axi_wr(32'h8, 32'h0);
    chk("bresp", rst_nmi_pkg::RESP_SLVERR, r);
    $display("test decode finished");
    // Interruptible power-down: wake needs the timing pin high at the edge
    axi_wr(32'h0, 32'h2);
    pulse_pd(1'h1);
    @(posedge aclk) nmi_lvl <= 1'h0;
    repeat (3) tick();
    chk("powerdown", 1, pd_act);
    @(posedge aclk) {tpin, nmi_lvl} <= 2'h3;
    @(posedge aclk) nmi_lvl <= 1'h0;
    repeat (2) tick();
    chk("powerdown", 0, pd_act);
    $display("test wake finished");
    tally_and_finish();
  end
endmodule // tb_reset_and_nmi_pin_control
